//--- qaw_answer_lut.sv
// expected answer byte for a question and byte position
`timescale 1ns/1ps
module qaw_answer_lut (
  // lookup key
  input  wire qaw_pkg::qaw_question_t question_in,
  input  wire qaw_pkg::qaw_pos_t      position_in,
  // expected byte
  output qaw_pkg::qaw_byte_t          expected_out
);
  import qaw_pkg::*;

  // fixed mixing of question and position; any bijection per position works
  always_comb begin
    case (position_in)
      2'h3:    expected_out = {question_in, ~question_in};
      2'h2:    expected_out = {~question_in, question_in} ^ 8'h5A;
      2'h1:    expected_out = {question_in[1:0], question_in, 2'h3};
      2'h0:    expected_out = {question_in ^ 4'hC, question_in ^ 4'h3};
      default: expected_out = 8'h00;
    endcase
  end

endmodule

//--- qaw_cfg.svh
// constants of the question and answer watchdog status block
`ifndef QAW_CFG_SVH
`define QAW_CFG_SVH

// system clock and watchdog time bases, in hertz
`define QAW_SYS_CLK_HZ     250000000
`define QAW_FCLK_FAST_HZ   64000
`define QAW_FCLK_SLOW_HZ   39000
// system clock cycles per watchdog clock period (rounded down)
`define QAW_TICK_FAST_CYC  (`QAW_SYS_CLK_HZ / `QAW_FCLK_FAST_HZ)
`define QAW_TICK_SLOW_CYC  (`QAW_SYS_CLK_HZ / `QAW_FCLK_SLOW_HZ)

// response time = one plus this step times the setting, in watchdog clocks
`define QAW_TIME_STEP      13'h0065
`define QAW_TIME_BASE      13'h0001
// fixed answer window: eight steps
`define QAW_WINDOW_LEN     13'h0328

// reset values
`define QAW_RESPONSE_TIME_SETTING_RST   6'h3F
`define QAW_ERRCNT_RST     3'h6
`define QAW_QUESTION_RST   4'h0
`define QAW_ANSCNT_RST     2'h3
`define QAW_SUBCNT_RST     3'h0
// wait length for the reset setting: one plus step times 3F
`define QAW_TIMER_RST      13'h18DC
`define QAW_QSTAT_RST      8'hE0
`define QAW_ASTAT_RST      8'hC0
`define QAW_ABORT_RST      8'h00

// fault when the error count is above this value
`define QAW_FAULT_LIMIT    3'h4
`define QAW_ERRCNT_MAX     3'h7
// question step, odd so every question is visited
`define QAW_QUESTION_STEP  4'h7

// field positions inside the status registers
`define QAW_QS_FAULT_BIT   7
`define QAW_AS_CNT_HI      7
`define QAW_AS_CUR_ERR     5
`define QAW_AS_ZERO        4
`define QAW_AS_CHANGED     3
`define QAW_AS_PREV_WRONG  2
`define QAW_AS_NO_ANSWER   1
`define QAW_AS_EARLY       0

`endif

//--- qaw_host_model.sv
// host side model issuing answer, time and read commands
`timescale 1ns/1ps
module qaw_host_model (
  // clock
  input  wire logic          clock_in,
  // commands towards the watchdog
  output logic               answer_byte_valid_out,
  output qaw_pkg::qaw_byte_t answer_byte_out,
  output logic               write_time_command_out,
  output qaw_pkg::qaw_byte_t write_time_data_out,
  output logic               read_block_eight_command_out,
  output logic               timebase_select_out
);
  import qaw_pkg::*;
  initial begin
    // base fixed before any run starts, never switched mid-run
    timebase_select_out          = 1'b1;
    answer_byte_valid_out        = 1'b0;
    write_time_command_out       = 1'b0;
    read_block_eight_command_out = 1'b0;
    answer_byte_out              = 8'h00;
    write_time_data_out          = 8'h00;
  end
  // kind 0 answer byte, 1 time write, 2 register read; one strobe cycle each
  task automatic command(input int kind, input qaw_byte_t data);
    @(negedge clock_in);
    answer_byte_valid_out        = (kind == 0);
    write_time_command_out       = (kind == 1);
    read_block_eight_command_out = (kind == 2);
    answer_byte_out              = data;
    write_time_data_out          = data;
    @(negedge clock_in);
    answer_byte_valid_out        = 1'b0;
    write_time_command_out       = 1'b0;
    read_block_eight_command_out = 1'b0;
    // idle data wanders so a stale byte never passes for a held one
    answer_byte_out              = qaw_byte_t'($urandom);
    write_time_data_out          = qaw_byte_t'($urandom);
  endtask
  // switch the watchdog time base between runs, never inside one
  task automatic select_base(input logic fast);
    @(negedge clock_in);
    timebase_select_out = fast;
  endtask
endmodule

//--- qaw_pkg.sv
// types shared by the question and answer watchdog status block
package qaw_pkg;

  typedef enum logic [0:0] {
    QAW_PH_WAIT   = 1'b0,
    QAW_PH_WINDOW = 1'b1
  } qaw_phase_t;

  typedef logic [7:0] qaw_byte_t;
  typedef logic [3:0] qaw_question_t;
  typedef logic [1:0] qaw_pos_t;
  typedef logic [5:0] qaw_time_t;

endpackage

//--- qaw_status.sv
// status and answer tracking of the question and answer watchdog
`include "qaw_cfg.svh"
`timescale 1ns/1ps
module qaw_status #(
  parameter int unsigned TICK_FAST_CYC = `QAW_TICK_FAST_CYC,
  parameter int unsigned TICK_SLOW_CYC = `QAW_TICK_SLOW_CYC
) (
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  // supervisor resets, one-cycle pulses
  input  wire logic               undervoltage_reset_in,
  input  wire logic               power_latch_reset_in,
  // decoded host commands
  input  wire logic               answer_byte_valid_in,
  input  wire qaw_pkg::qaw_byte_t answer_byte_in,
  input  wire logic               write_time_command_in,
  input  wire qaw_pkg::qaw_byte_t write_time_data_in,
  input  wire logic               read_block_eight_command_in,
  // time base select, high for the fast base
  input  wire logic               timebase_select_in,
  // register images
  output qaw_pkg::qaw_byte_t      effective_response_time_mirror_out,
  output qaw_pkg::qaw_byte_t      question_and_error_status_out,
  output qaw_pkg::qaw_byte_t      answer_check_status_out,
  output qaw_pkg::qaw_byte_t      abort_and_reset_counters_out,
  // consequences of errors
  output logic                    watchdog_fault_flag_out,
  output logic                    watchdog_reset_out,
  output logic                    shutdown_request_out
);
  import qaw_pkg::*;

  // response time in watchdog clocks for a setting
  function automatic logic [12:0] resp_len(input qaw_time_t setting);
    resp_len = `QAW_TIME_BASE + 13'(setting) * `QAW_TIME_STEP;
  endfunction

  // saturating three-bit increment
  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    sat_inc = (v == `QAW_ERRCNT_MAX) ? v : v + 3'h1;
  endfunction

  // reset synchroniser
  logic rst_meta_q;
  logic rst_sync_q;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_q;

  // watchdog clock tick from the system clock
  logic [12:0] presc_q;
  logic        tick_q;
  logic [12:0] presc_top;
  // the select is sampled every clock cycle, so the host must set it before a run
  assign presc_top = timebase_select_in ? 13'(TICK_FAST_CYC - 1)
                                        : 13'(TICK_SLOW_CYC - 1);
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      presc_q <= 13'h0000;
      tick_q  <= 1'b0;
    end else if (presc_q >= presc_top) begin
      presc_q <= 13'h0000;
      tick_q  <= 1'b1;
    end else begin
      presc_q <= presc_q + 13'h0001;
      tick_q  <= 1'b0;
    end
  end

  // state
  qaw_time_t     mirror_q;
  logic          init_wdr_q;
  qaw_question_t question_q;
  logic [2:0]    error_count_q;
  qaw_pos_t      ans_cnt_q;
  logic          cur_err_q;
  logic          prev_wrong_q;
  logic          changed_q;
  logic          no_answer_q;
  logic          early_q;
  qaw_phase_t    phase_q;
  logic [12:0]   timer_q;
  logic [2:0]    shutdown_cnt_q;
  logic [2:0]    reset_evt_cnt_q;

  // expected byte for the position being awaited
  qaw_byte_t expected;
  qaw_answer_lut u_lut (
    .question_in  (question_q),
    .position_in  (ans_cnt_q),
    .expected_out (expected)
  );

  // event decode
  logic byte_bad;
  logic complete;
  logic phase_done;
  logic time_wr;
  logic ans_done;
  logic win_end;
  logic run;
  logic early;
  logic run_err;
  logic zero_time;
  logic err_inc;
  logic err_dec;
  logic overflow;

  always_comb begin
    zero_time  = (mirror_q == 6'h00);
    byte_bad   = answer_byte_valid_in && (answer_byte_in != expected);
    complete   = answer_byte_valid_in && (ans_cnt_q == 2'h0);
    phase_done = tick_q && (timer_q == 13'h0001);
    time_wr    = write_time_command_in;
    // one run per cycle: a time write outranks an answer, which outranks the window
    ans_done   = complete && !time_wr;
    win_end    = phase_done && (phase_q == QAW_PH_WINDOW) && !time_wr && !ans_done;
    run        = time_wr || ans_done || win_end;
    early      = ans_done && (phase_q == QAW_PH_WAIT);
    run_err    = cur_err_q || byte_bad;
    err_inc    = time_wr
              || (ans_done && (early || run_err || zero_time))
              || win_end;
    err_dec    = ans_done && !early && !run_err && !zero_time;
    overflow   = err_inc && (error_count_q == `QAW_ERRCNT_MAX);
  end

  // response time setting and its mirror
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      mirror_q   <= `QAW_RESPONSE_TIME_SETTING_RST;
      init_wdr_q <= 1'b0;
    end else if (undervoltage_reset_in || power_latch_reset_in) begin
      mirror_q   <= `QAW_RESPONSE_TIME_SETTING_RST;
      init_wdr_q <= 1'b0;
    end else if (time_wr) begin
      mirror_q   <= write_time_data_in[5:0];
      init_wdr_q <= write_time_data_in[7];
    end
  end

  // question and error counter
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      question_q <= `QAW_QUESTION_RST;
      error_count_q  <= `QAW_ERRCNT_RST;
    end else if (undervoltage_reset_in) begin
      question_q <= `QAW_QUESTION_RST;
      error_count_q  <= `QAW_ERRCNT_RST;
    end else begin
      if (power_latch_reset_in) begin
        error_count_q <= `QAW_ERRCNT_RST;
      end else if (err_inc) begin
        error_count_q <= sat_inc(error_count_q);
      end else if (err_dec && error_count_q != 3'h0) begin
        error_count_q <= error_count_q - 3'h1;
      end
      // a time write run reuses the question being asked
      if (ans_done || win_end) begin
        question_q <= question_q + `QAW_QUESTION_STEP;
      end
    end
  end

  // answer byte counter and answer error flags
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ans_cnt_q    <= `QAW_ANSCNT_RST;
      cur_err_q    <= 1'b0;
      prev_wrong_q <= 1'b0;
    end else if (undervoltage_reset_in) begin
      ans_cnt_q    <= `QAW_ANSCNT_RST;
      cur_err_q    <= 1'b0;
      prev_wrong_q <= 1'b0;
    end else if (run) begin
      ans_cnt_q    <= `QAW_ANSCNT_RST;
      prev_wrong_q <= run_err;
      cur_err_q    <= 1'b0;
    end else if (answer_byte_valid_in) begin
      ans_cnt_q <= ans_cnt_q - 2'h1;
      if (byte_bad) begin
        cur_err_q <= 1'b1;
      end
    end
  end

  // change, no answer and early flags; a set always beats a read clear
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      changed_q   <= 1'b0;
      no_answer_q <= 1'b0;
      early_q     <= 1'b0;
    end else if (undervoltage_reset_in) begin
      changed_q   <= 1'b0;
      no_answer_q <= 1'b0;
      early_q     <= 1'b0;
    end else begin
      if (time_wr) begin
        changed_q <= 1'b1;
      end else if (run || read_block_eight_command_in) begin
        changed_q <= 1'b0;
      end
      if (win_end) begin
        no_answer_q <= 1'b1;
      end else if (early) begin
        no_answer_q <= 1'b0;
      end else if (read_block_eight_command_in) begin
        no_answer_q <= 1'b0;
      end
      if (run) begin
        early_q <= early;
      end
    end
  end

  // time window sequencer; restarts on every run, including a missed window
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= QAW_PH_WAIT;
      timer_q <= `QAW_TIMER_RST;
    end else if (undervoltage_reset_in) begin
      phase_q <= QAW_PH_WAIT;
      timer_q <= resp_len(`QAW_RESPONSE_TIME_SETTING_RST);
    end else if (run) begin
      // the run uses the time in force before a write in the same cycle
      phase_q <= QAW_PH_WAIT;
      timer_q <= resp_len(mirror_q);
    end else if (phase_done) begin
      phase_q <= QAW_PH_WINDOW;
      timer_q <= `QAW_WINDOW_LEN;
    end else if (tick_q) begin
      timer_q <= timer_q - 13'h0001;
    end
  end

  // overflow consequences: shutdown and reset counters
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      shutdown_cnt_q       <= `QAW_SUBCNT_RST;
      reset_evt_cnt_q      <= `QAW_SUBCNT_RST;
      watchdog_reset_out   <= 1'b0;
      shutdown_request_out <= 1'b0;
    end else if (undervoltage_reset_in) begin
      shutdown_cnt_q       <= `QAW_SUBCNT_RST;
      reset_evt_cnt_q      <= `QAW_SUBCNT_RST;
      watchdog_reset_out   <= 1'b0;
      shutdown_request_out <= 1'b0;
    end else begin
      watchdog_reset_out <= overflow && init_wdr_q;
      if (overflow) begin
        shutdown_cnt_q <= sat_inc(shutdown_cnt_q);
        if (shutdown_cnt_q == `QAW_ERRCNT_MAX) begin
          shutdown_request_out <= 1'b1;
        end
        if (init_wdr_q) begin
          reset_evt_cnt_q <= sat_inc(reset_evt_cnt_q);
        end
      end
    end
  end

  // register images, one cycle behind the state
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      effective_response_time_mirror_out <= {2'h0, `QAW_RESPONSE_TIME_SETTING_RST};
      question_and_error_status_out      <= `QAW_QSTAT_RST;
      answer_check_status_out            <= `QAW_ASTAT_RST;
      abort_and_reset_counters_out       <= `QAW_ABORT_RST;
      watchdog_fault_flag_out            <= 1'b1;
    end else begin
      effective_response_time_mirror_out <= {2'h0, mirror_q};
      question_and_error_status_out      <= {(error_count_q > `QAW_FAULT_LIMIT),
                                             error_count_q, question_q};
      question_and_error_status_out[`QAW_QS_FAULT_BIT] <=
        (error_count_q > `QAW_FAULT_LIMIT);
      answer_check_status_out <= {ans_cnt_q, cur_err_q, zero_time,
                                  changed_q, prev_wrong_q,
                                  no_answer_q, early_q};
      abort_and_reset_counters_out <= {2'h0, shutdown_cnt_q,
                                       reset_evt_cnt_q};
      watchdog_fault_flag_out <= (error_count_q > `QAW_FAULT_LIMIT);
    end
  end

endmodule

//--- qaw_status_monitor.sv
// concurrent checks on the ports of the watchdog status block
`timescale 1ns/1ps
module qaw_status_monitor (
  // clock and reset
  input  wire logic               clock_in,
  input  wire logic               rst_n_in,
  // supervisor resets
  input  wire logic               undervoltage_reset_in,
  input  wire logic               power_latch_reset_in,
  // host commands
  input  wire logic               answer_byte_valid_in,
  input  wire logic               write_time_command_in,
  input  wire qaw_pkg::qaw_byte_t write_time_data_in,
  input  wire logic               read_block_eight_command_in,
  // register images
  input  wire qaw_pkg::qaw_byte_t effective_response_time_mirror_out,
  input  wire qaw_pkg::qaw_byte_t question_and_error_status_out,
  input  wire qaw_pkg::qaw_byte_t answer_check_status_out,
  input  wire qaw_pkg::qaw_byte_t abort_and_reset_counters_out
);
  import qaw_pkg::*;
  wire qaw_byte_t mir   = effective_response_time_mirror_out;
  wire qaw_byte_t qs    = question_and_error_status_out;
  wire qaw_byte_t ans   = answer_check_status_out;
  wire logic      wt    = write_time_command_in;
  wire logic      av    = answer_byte_valid_in;
  wire logic      quiet = !undervoltage_reset_in && !power_latch_reset_in;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  a_mirror_top_zero: assert property (mir[7:6] == 2'b00)
    else $error("mirror upper bits not zero");
  a_fault_bit_count: assert property (qs[7] == (qs[6:4] > 3'h4))
    else $error("fault bit disagrees with error count");
  a_abort_top_zero: assert property (abort_and_reset_counters_out[7:6] == 2'b00)
    else $error("abort counter upper bits not zero");
  a_time_sets_changed: assert property (wt && quiet |-> ##2 ans[3])
    else $error("time write did not flag a change");
  a_read_clears_changed: assert property (
    (read_block_eight_command_in && !wt && quiet) ##1 (!wt && quiet) |=> !ans[3])
    else $error("read did not clear the change flag");
  a_zero_flag_set: assert property (wt && quiet && write_time_data_in[5:0] == 6'h00
    |-> ##2 ans[4])
    else $error("zero time not flagged");
  a_mirror_follows: assert property (wt && quiet
    |-> ##2 mir == {2'b00, $past(write_time_data_in[5:0], 2)})
    else $error("mirror does not follow the written setting");
  a_counter_first_step: assert property (av && quiet && !wt && ans[7:6] == 2'b11
    && !$past(av) && !$past(av, 2) |-> ##2 ans[7:6] == 2'b10)
    else $error("byte counter did not step from three to two");
  a_uv_restores: assert property (undervoltage_reset_in
    |-> ##2 qs == 8'hE0 && ans == 8'hC0)
    else $error("undervoltage reset did not restore status");
  a_latch_partial: assert property (power_latch_reset_in && !undervoltage_reset_in
    |-> ##2 qs[6:4] == 3'h6 && !ans[4] && mir == 8'h3F)
    else $error("power latch reset did not restore its fields");

  c_no_answer: cover property (ans[1]);
  c_early: cover property (ans[0] && ans[2]);
  c_zero_time: cover property (ans[4] && !qs[7]);
endmodule

bind qaw_status qaw_status_monitor qaw_status_monitor_i (
  .clock_in(clock_in), .rst_n_in(rst_n_in),
  .undervoltage_reset_in(undervoltage_reset_in), .power_latch_reset_in(power_latch_reset_in),
  .answer_byte_valid_in(answer_byte_valid_in), .write_time_command_in(write_time_command_in),
  .write_time_data_in(write_time_data_in),
  .read_block_eight_command_in(read_block_eight_command_in),
  .effective_response_time_mirror_out(effective_response_time_mirror_out),
  .question_and_error_status_out(question_and_error_status_out),
  .answer_check_status_out(answer_check_status_out),
  .abort_and_reset_counters_out(abort_and_reset_counters_out)
);

//--- tb_qaw_status.sv
// self-checking bench of the watchdog status block against an integer model
`timescale 1ns/1ps
module tb_qaw_status;
  import qaw_pkg::*;
  logic      clock_in, rst_n_in, uv, pl;
  wire logic av, wt, rd, tbs, fault, wrst, sd;
  qaw_byte_t ab, wd, mir, qs, as, abt;
  int        err, q, setting, cnt, cur, prev, zero, chg, noans, early;
  int        failures, n_tests, i, seed;
  int        sdc, rstc, shut, wdr, exp_pulses, rst_pulses;

  qaw_status #(.TICK_FAST_CYC(4), .TICK_SLOW_CYC(6)) qaw_status_i (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .undervoltage_reset_in(uv),
    .power_latch_reset_in(pl), .answer_byte_valid_in(av), .answer_byte_in(ab),
    .write_time_command_in(wt), .write_time_data_in(wd), .read_block_eight_command_in(rd),
    .timebase_select_in(tbs), .effective_response_time_mirror_out(mir),
    .question_and_error_status_out(qs), .answer_check_status_out(as),
    .abort_and_reset_counters_out(abt), .watchdog_fault_flag_out(fault),
    .watchdog_reset_out(wrst), .shutdown_request_out(sd));
  qaw_host_model qaw_host_model_i (
    .clock_in(clock_in), .answer_byte_valid_out(av), .answer_byte_out(ab),
    .write_time_command_out(wt), .write_time_data_out(wd),
    .read_block_eight_command_out(rd), .timebase_select_out(tbs));

  initial begin
    clock_in = 1'b0;
    forever #2 clock_in = ~clock_in;
  end
  // the reset request stands one cycle, so it is counted mid-cycle
  always @(negedge clock_in) begin
    if (wrst === 1'b1) rst_pulses++;
  end

  task automatic finish_test();
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic qaw_byte_t exp_byte(input int qi, input int pos);
    logic [3:0] qq;
    qq = qi[3:0];
    case (pos)
      3: return {qq, ~qq};
      2: return {~qq, qq} ^ 8'h5A;
      1: return {qq[1:0], qq, 2'b11};
      default: return {qq ^ 4'hC, qq ^ 4'h3};
    endcase
  endfunction
  task automatic model_reset();
    err = 6; q = 0; setting = 63; cnt = 3; cur = 0;
    prev = 0; zero = 0; chg = 0; noans = 0; early = 0;
    sdc = 0; rstc = 0; shut = 0; wdr = 0;
  endtask
  task automatic check_all();
    repeat (3) @(negedge clock_in);
    check(mir, {2'b00, setting[5:0]});
    check(qs, {err > 4, err[2:0], q[3:0]});
    check(as, {cnt[1:0], cur[0], zero[0], chg[0], prev[0], noans[0], early[0]});
    check(abt, {2'b00, sdc[2:0], rstc[2:0]});
    check(fault, err > 4);
    check(sd, shut[0]);
    check(8'(rst_pulses), 8'(exp_pulses));
  endtask
  // saturating error counter; an increment at seven overflows into the abort counters
  task automatic bump(input int d);
    if (d > 0 && err == 7) begin
      if (sdc == 7) shut = 1;
      if (wdr != 0) begin
        rstc = (rstc == 7) ? 7 : rstc + 1;
        exp_pulses++;
      end
      sdc = (sdc == 7) ? 7 : sdc + 1;
    end
    err = (err + d > 7) ? 7 : (err + d < 0) ? 0 : err + d;
  endtask
  task automatic run_end(input int next_q);
    prev = cur;
    cur = 0; cnt = 3; early = 0; q = next_q;
  endtask
  task automatic answer(input int wrong, input int in_window);
    qaw_byte_t b;
    for (int pos = 3; pos >= 0; pos--) begin
      b = exp_byte(q, pos);
      if (pos == wrong) b = b ^ qaw_byte_t'($urandom % 255 + 1);
      qaw_host_model_i.command(0, b);
      if (pos == wrong) cur = 1;
      if (pos > 0) begin
        cnt = pos - 1;
        check_all();
      end
    end
    if (!in_window || cur != 0 || setting == 0) bump(1);
    else bump(-1);
    run_end((q + 7) % 16);
    chg = 0;
    early = !in_window;
    if (!in_window) noans = 0;
    check_all();
  endtask
  task automatic set_time(input int d);
    qaw_host_model_i.command(1, qaw_byte_t'(d));
    bump(1);
    run_end(q);
    // the reset enable in force before the write decides this overflow
    wdr = d / 128;
    chg = 1; setting = d % 64; zero = (setting == 0);
    check_all();
  endtask
  task automatic read_regs();
    qaw_host_model_i.command(2, 8'h00);
    chg = 0; noans = 0;
    check_all();
  endtask

  initial begin
    seed = $urandom(32'h3d218b71);
    failures = 0; n_tests = 0; rst_pulses = 0; exp_pulses = 0;
    rst_n_in = 1'b0; uv = 1'b0; pl = 1'b0;
    model_reset();
    repeat (5) @(negedge clock_in);
    rst_n_in = 1'b1;
    check_all();
    check(abt, 8'h00);
    answer(2, 0);
    set_time(1);
    read_regs();
    // old setting still times this run, so the window closes unanswered
    for (i = 0; i < 40000 && as[1] !== 1'b1; i++) @(negedge clock_in);
    if (i == 40000) begin
      failures++;
      finish_test();
    end
    noans = 1;
    bump(1);
    run_end((q + 7) % 16);
    chg = 0;
    check_all();
    repeat (3) begin
      repeat (500) @(negedge clock_in);
      answer(-1, 1);
    end
    read_regs();
    set_time(8'h80);
    repeat (500) @(negedge clock_in);
    answer(-1, 1);
    // slow base from here: the next wait outlasts the answer, so it lands early
    qaw_host_model_i.select_base(1'b0);
    set_time(8'h81);
    set_time(8'h81);
    repeat (500) @(negedge clock_in);
    answer(-1, 0);
    @(negedge clock_in) pl = 1'b1;
    @(negedge clock_in) pl = 1'b0;
    err = 6; setting = 63; zero = 0; wdr = 0;
    check_all();
    @(negedge clock_in) uv = 1'b1;
    @(negedge clock_in) uv = 1'b0;
    model_reset();
    check_all();
    check(abt, 8'h00);
    finish_test();
  end
endmodule
